// ==== spi_master_slave_port.sv ====
// The strobed register port was chosen for this implementation.
`timescale 1ns/10ps
`include "spi_port_consts.svh"

// Function
// - Shift clock output as master, input as slave
// - Master ignores slave-select input
// - Slave active only while select held low
// - Normal master write starts clock and shifts
// - First bit waits for next half-slot boundary
// - Byte done: stop clock, flag, buffer received
// - Interrupt needs both enables set
// - Data window write transmits, read receives
// - Normal write during transfer flags collision, dropped
// - Buffered write loads holding byte, flags full
// - Full flag cleared when byte enters shifter
// - Idle master sends buffered byte at once
// - Load window open first four bit slots
// - Waiting byte chains without stopping the clock
// - Port enable connects pins, clear disables
// - Bit order selects LSB or MSB first
// - Master select picks role and data directions
// - Clock idle level sets idle clock state
// - Phase and idle level pick timing format
// - Rate bits divide clock by 4/8/32/64
// - Unloaded slave echoes received byte
// - Mode bit selects normal or buffered writes
// - Status read then data access clears flag
module spi_master_slave_port #(
  parameter int BYTE_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire spi_port_pkg::reg_byte_type regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  output spi_port_pkg::reg_byte_type regRdData,
  input wire logic serialIrqEnable,
  output logic irqReq,
  input wire logic sckIn,
  output logic sckOut,
  output logic sckOe,
  input wire logic mosiIn,
  output logic mosiOut,
  output logic mosiOe,
  input wire logic misoIn,
  output logic misoOut,
  output logic misoOe,
  input wire logic slaveSelectN
);
  import spi_port_pkg::*;

  localparam int HW = $clog2(2 * BYTE_W);
  localparam int CW = $clog2(BYTE_W);
  localparam logic [HW-1:0] H_LAST = HW'(2 * BYTE_W - 1);
  localparam logic [HW-1:0] H_WIN = HW'(2 * `SPI_LOAD_WIN_BITS);
  localparam logic [CW-1:0] C_LAST = CW'(BYTE_W - 1);
  localparam logic [CW-1:0] C_WIN = CW'(`SPI_LOAD_WIN_BITS);

  // Bytes wider than the register port cannot be reached by software
  initial
  begin
    if (BYTE_W < 5 || BYTE_W > 8)
      $error("BYTE_W must lie between 5 and 8");
  end

  reg_byte_type ctrlReg;
  logic modeReg;
  logic dissoReg;
  logic eotReg;
  logic wcolReg;
  logic armedReg;
  logic [BYTE_W-1:0] shiftReg;
  logic [BYTE_W-1:0] holdReg;
  logic [BYTE_W-1:0] rxBufReg;
  logic holdFullReg;
  logic outBitReg;
  logic sckReg;
  logic startPendReg;
  logic [4:0] prescReg;
  logic [HW-1:0] halfReg;
  logic [CW-1:0] slvCntReg;
  logic sckPrevReg;
  master_state_type stateReg;
  logic [3:0] syncStage1Reg;
  logic [3:0] syncStage2Reg;

  // Control fields
  logic irqEn;
  logic portEn;
  logic lsbFirst;
  logic masterSel;
  logic idleLevel;
  logic phaseSel;
  logic [1:0] rateSel;
  assign irqEn = ctrlReg[`SPI_CTRL_IRQEN_BIT];
  assign portEn = ctrlReg[`SPI_CTRL_PORTEN_BIT];
  assign lsbFirst = ctrlReg[`SPI_CTRL_ORDER_BIT];
  assign masterSel = ctrlReg[`SPI_CTRL_MASTER_BIT];
  assign idleLevel = ctrlReg[`SPI_CTRL_IDLE_BIT];
  assign phaseSel = ctrlReg[`SPI_CTRL_PHASE_BIT];
  assign rateSel = {ctrlReg[`SPI_CTRL_RATE1_BIT], ctrlReg[`SPI_CTRL_RATE0_BIT]};

  // Two-flop synchronisers for all pin inputs: clock, mosi, miso, select
  logic [3:0] pinRaw;
  assign pinRaw = {sckIn, mosiIn, misoIn, slaveSelectN};
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge sys_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          syncStage1Reg[gi] <= 1'b1;
          syncStage2Reg[gi] <= 1'b1;
        end
        else
        begin
          syncStage1Reg[gi] <= pinRaw[gi];
          syncStage2Reg[gi] <= syncStage1Reg[gi];
        end
      end
    end
  endgenerate

  logic sckSync;
  logic mosiSync;
  logic misoSync;
  logic selSyncN;
  assign sckSync = syncStage2Reg[3];
  assign mosiSync = syncStage2Reg[2];
  assign misoSync = syncStage2Reg[1];
  assign selSyncN = syncStage2Reg[0];

  // Register port decode
  logic ctrlWr;
  logic statWr;
  logic statRd;
  logic dataWr;
  logic dataRd;
  assign ctrlWr = regWrStrobe && regAddr == `SPI_CTRL_OFF;
  assign statWr = regWrStrobe && regAddr == `SPI_STATUS_OFF;
  assign statRd = regRdStrobe && regAddr == `SPI_STATUS_OFF;
  assign dataWr = regWrStrobe && regAddr == `SPI_DATA_OFF;
  assign dataRd = regRdStrobe && regAddr == `SPI_DATA_OFF;

  // Role and selection; the select pin only matters in slave role
  logic masterOn;
  logic slaveOn;
  logic selected;
  assign masterOn = portEn && masterSel;
  assign slaveOn = portEn && !masterSel;
  assign selected = slaveOn && !selSyncN;

  // Master bit-slot timing; rate bits are ignored in slave role
  logic [4:0] halfDiv;
  logic tick;
  always_comb
  begin
    unique case (rateSel)
      2'b00: halfDiv = `SPI_HALF_DIV0;
      2'b01: halfDiv = `SPI_HALF_DIV1;
      2'b10: halfDiv = `SPI_HALF_DIV2;
      2'b11: halfDiv = `SPI_HALF_DIV3;
    endcase
  end
  assign tick = masterOn && prescReg == halfDiv - 5'h01;

  // Slave clock edges, seen only while selected
  logic sckChange;
  logic sckLead;
  logic sckTrail;
  assign sckChange = selected && sckSync != sckPrevReg;
  assign sckLead = sckChange && sckSync != idleLevel;
  assign sckTrail = sckChange && sckSync == idleLevel;

  // Sample and drive events for both roles
  logic mstSample;
  logic mstDrive;
  logic mstDone;
  logic slvSample;
  logic slvDrive;
  logic slvDone;
  // Master samples at the end of each second half slot, so the far side's
  // bit has crossed the two-flop synchroniser even at divide by 4
  assign mstSample = stateReg == MST_SHIFT && tick && halfReg[0];
  assign mstDone = stateReg == MST_SHIFT && tick && halfReg == H_LAST;
  assign mstDrive = mstSample && !mstDone;
  assign slvSample = phaseSel ? sckTrail : sckLead;
  assign slvDrive = phaseSel ? sckLead : sckTrail;
  assign slvDone = slvSample && slvCntReg == C_LAST;

  // Write handling for both modes
  logic busy;
  logic xferDone;
  logic collide;
  logic directLoad;
  logic holdLoad;
  logic unloadIdle;
  logic chain;
  assign busy = masterOn ? (stateReg == MST_SHIFT || startPendReg) : (selected && slvCntReg != '0);
  assign xferDone = mstDone || slvDone;
  assign collide = dataWr && !modeReg && busy;
  assign directLoad = dataWr && !modeReg && !busy && !slvSample;
  assign holdLoad = dataWr && modeReg;
  assign unloadIdle = modeReg && holdFullReg && !busy && !slvSample;
  assign chain = xferDone && modeReg && holdFullReg;

  // Shift helpers
  logic inBit;
  logic [BYTE_W-1:0] shifted;
  logic srTop;
  logic holdTop;
  assign inBit = masterOn ? misoSync : mosiSync;
  assign shifted = lsbFirst ? {inBit, shiftReg[BYTE_W-1:1]} : {shiftReg[BYTE_W-2:0], inBit};
  assign srTop = lsbFirst ? shiftReg[0] : shiftReg[BYTE_W-1];
  assign holdTop = lsbFirst ? holdReg[0] : holdReg[BYTE_W-1];
  logic shTop;
  assign shTop = lsbFirst ? shifted[0] : shifted[BYTE_W-1];

  logic loadWin;
  assign loadWin = masterOn ? (stateReg == MST_SHIFT && halfReg < H_WIN) : (selected && slvCntReg < C_WIN);

  // Control register
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      ctrlReg <= `SPI_CTRL_RESET;
    else if (ctrlWr)
      ctrlReg <= regWrData;
  end

  // Writable status bits: write mode and slave output disable
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      modeReg <= 1'b0;
      dissoReg <= 1'b0;
    end
    else if (statWr)
    begin
      modeReg <= regWrData[`SPI_STAT_MODE_BIT];
      dissoReg <= regWrData[`SPI_STAT_DISSO_BIT];
    end
  end

  // Free-running prescaler so bit slots stay aligned to the rate
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      prescReg <= 5'h00;
    else if (!masterOn || tick)
      prescReg <= 5'h00;
    else
      prescReg <= prescReg + 5'h01;
  end

  // Start request; the engine picks it up on the next slot boundary
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      startPendReg <= 1'b0;
    else if (!masterOn)
      startPendReg <= 1'b0;
    else if (directLoad || unloadIdle)
      startPendReg <= 1'b1;
    else if (stateReg == MST_IDLE && tick)
      startPendReg <= 1'b0;
  end

  // Master engine: sixteen half slots per byte
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      stateReg <= MST_IDLE;
      halfReg <= '0;
    end
    else if (!masterOn)
    begin
      stateReg <= MST_IDLE;
      halfReg <= '0;
    end
    else
    begin
      unique case (stateReg)
        MST_IDLE:
        begin
          halfReg <= '0;
          if (startPendReg && tick)
            stateReg <= MST_SHIFT;
        end
        MST_SHIFT:
        begin
          if (mstDone)
          begin
            halfReg <= '0;
            stateReg <= chain ? MST_SHIFT : MST_IDLE;
          end
          else if (tick)
            halfReg <= halfReg + HW'(1);
        end
      endcase
    end
  end

  // Master clock pin level; one system clock later than the data it frames
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      sckReg <= 1'b0;
    else if (stateReg == MST_SHIFT)
      sckReg <= idleLevel ^ (halfReg[0] ^ phaseSel);
    else
      sckReg <= idleLevel;
  end

  // Slave edge history and bit count; deselect aborts the byte
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sckPrevReg <= 1'b0;
      slvCntReg <= '0;
    end
    else
    begin
      sckPrevReg <= sckSync;
      if (!selected)
        slvCntReg <= '0;
      else if (slvSample)
        slvCntReg <= slvDone ? '0 : slvCntReg + CW'(1);
    end
  end

  // Shift register and receive buffer; the shifter keeps the last byte,
  // so an unloaded slave echoes it back
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      shiftReg <= '0;
      rxBufReg <= '0;
    end
    else if (xferDone)
    begin
      rxBufReg <= shifted;
      shiftReg <= chain ? holdReg : shifted;
    end
    else if (mstSample || slvSample)
      shiftReg <= shifted;
    else if (directLoad)
      shiftReg <= regWrData[BYTE_W-1:0];
    else if (unloadIdle)
      shiftReg <= holdReg;
  end

  // Outgoing bit; idle keeps the next first bit presented
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      outBitReg <= 1'b0;
    else if (chain && masterOn)
      outBitReg <= holdTop;
    else if (mstDrive)
      outBitReg <= shTop; // Next bit comes from the freshly shifted register value, not the incoming bit
    else if (slvDrive)
      outBitReg <= srTop;
    else if (masterOn ? stateReg == MST_IDLE : slvCntReg == '0)
      outBitReg <= srTop;
  end

  // Transmit holding buffer for buffered mode
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      holdReg <= '0;
      holdFullReg <= 1'b0;
    end
    else
    begin
      if (holdLoad)
        holdReg <= regWrData[BYTE_W-1:0];
      if (holdLoad)
        holdFullReg <= 1'b1;
      else if (unloadIdle || chain)
        holdFullReg <= 1'b0;
    end
  end

  // Status read arms the flag clear done by the next data access
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      armedReg <= 1'b0;
    else if (statRd)
      armedReg <= 1'b1;
    else if (dataRd || dataWr)
      armedReg <= 1'b0;
  end

  // End-of-transfer flag; a new event beats the clear
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      eotReg <= 1'b0;
    else if (xferDone)
      eotReg <= 1'b1;
    else if (armedReg && (dataRd || dataWr))
      eotReg <= 1'b0;
  end

  // Collision flag doubles as buffer-full indicator in buffered mode
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      wcolReg <= 1'b0;
    else if (collide || holdLoad)
      wcolReg <= 1'b1;
    else if (modeReg && (unloadIdle || chain))
      wcolReg <= 1'b0;
    else if (!modeReg && armedReg && (dataRd || dataWr))
      wcolReg <= 1'b0;
  end

  // Read data, valid only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
      regRdData <= `SPI_DATA_RESET;
    else if (!regRdStrobe)
      regRdData <= 8'h00;
    else if (regAddr == `SPI_CTRL_OFF)
      regRdData <= ctrlReg;
    else if (regAddr == `SPI_STATUS_OFF)
      regRdData <= {eotReg, wcolReg, loadWin, 3'h0, dissoReg, modeReg};
    else if (regAddr == `SPI_DATA_OFF)
      regRdData <= 8'(rxBufReg);
    else
      regRdData <= 8'h00;
  end

  // Pin drivers; nothing drives while the port is off
  assign sckOut = sckReg;
  assign sckOe = masterOn;
  assign mosiOut = outBitReg;
  assign mosiOe = masterOn;
  assign misoOut = outBitReg;
  assign misoOe = selected && !dissoReg;

  // Interrupt request gated by both enables
  assign irqReq = eotReg && irqEn && serialIrqEnable;

endmodule : spi_master_slave_port

// ==== spi_port_consts.svh ====
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// Register offsets on the plain register port
`define SPI_CTRL_OFF 8'hD5
`define SPI_STATUS_OFF 8'hAA
`define SPI_DATA_OFF 8'h86

// Control register fields
`define SPI_CTRL_IRQEN_BIT 7
`define SPI_CTRL_PORTEN_BIT 6
`define SPI_CTRL_ORDER_BIT 5
`define SPI_CTRL_MASTER_BIT 4
`define SPI_CTRL_IDLE_BIT 3
`define SPI_CTRL_PHASE_BIT 2
`define SPI_CTRL_RATE1_BIT 1
`define SPI_CTRL_RATE0_BIT 0
`define SPI_CTRL_RESET 8'h00

// Status register fields
`define SPI_STAT_EOT_BIT 7
`define SPI_STAT_WRITE_COLLISION_FLAG_BIT 6
`define SPI_STAT_LDWIN_BIT 5
`define SPI_STAT_DISSO_BIT 1
`define SPI_STAT_MODE_BIT 0
`define SPI_DATA_RESET 8'h00

// Half shift-clock periods in system clocks for divide by 4, 8, 32, 64
`define SPI_HALF_DIV0 5'h02
`define SPI_HALF_DIV1 5'h04
`define SPI_HALF_DIV2 5'h10
`define SPI_HALF_DIV3 5'h20

// Bit slots at the start of a byte during which the load window is open
`define SPI_LOAD_WIN_BITS 4

`endif

// ==== spi_port_pkg.sv ====
package spi_port_pkg;

  // Master shift engine states
  typedef enum logic [0:0] {
    MST_IDLE,
    MST_SHIFT
  } master_state_type;

  typedef logic [7:0] reg_byte_type;

endpackage : spi_port_pkg

// ==== spi_master_slave_port_properties.sv ====
`timescale 1ns/10ps
`include "spi_port_consts.svh"

module spi_master_slave_port_properties #(
  parameter int BYTE_W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [7:0] regAddr,
  input wire spi_port_pkg::reg_byte_type regWrData,
  input wire logic regWrStrobe,
  input wire logic regRdStrobe,
  input wire spi_port_pkg::reg_byte_type regRdData,
  input wire logic serialIrqEnable,
  input wire logic irqReq,
  input wire logic sckIn,
  input wire logic sckOut,
  input wire logic sckOe,
  input wire logic mosiIn,
  input wire logic mosiOut,
  input wire logic mosiOe,
  input wire logic misoIn,
  input wire logic misoOut,
  input wire logic misoOe,
  input wire logic slaveSelectN
);
  import spi_port_pkg::*;
  reg_byte_type ctrlReg;
  logic armedReg;
  logic dataAcc;
  logic mapped;
  logic modeSh;

  // Shadow of the buffered-mode bit; chained bytes keep the clock running
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) modeSh <= 1'b0;
    else if (regWrStrobe && regAddr == `SPI_STATUS_OFF) modeSh <= regWrData[`SPI_STAT_MODE_BIT];

  // Address decode seen from the bus side
  assign dataAcc = (regRdStrobe || regWrStrobe) && regAddr == `SPI_DATA_OFF;
  assign mapped = regAddr == `SPI_CTRL_OFF || regAddr == `SPI_STATUS_OFF || regAddr == `SPI_DATA_OFF;

  // Shadow of the control register; only bus writes change it
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) ctrlReg <= `SPI_CTRL_RESET;
    else if (regWrStrobe && regAddr == `SPI_CTRL_OFF) ctrlReg <= regWrData;

  // Armed by a status read while irqReq is high, so a plain data access never counts
  always_ff @(posedge sys_clk or negedge arst_n)
    if (!arst_n) armedReg <= 1'b0;
    else if (regRdStrobe && regAddr == `SPI_STATUS_OFF && irqReq) armedReg <= 1'b1;
    else if (dataAcc) armedReg <= 1'b0;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_read_idle: assert property (!regRdStrobe |=> regRdData == 8'h00)
    else $error("Read data not zero outside read cycle");
  a_unmapped_zero: assert property (regRdStrobe && !mapped |=> regRdData == 8'h00)
    else $error("Unmapped read not zero");
  a_ctrl_readback: assert property (regRdStrobe && regAddr == `SPI_CTRL_OFF |=> regRdData == ctrlReg)
    else $error("Control read differs from last write");
  a_sck_dir: assert property (sckOe == (ctrlReg[6] && ctrlReg[4]))
    else $error("Shift clock drive wrong for role");
  a_data_dir: assert property (mosiOe == sckOe && !(ctrlReg[4] && misoOe))
    else $error("Data line directions wrong for role");
  a_irq_gated: assert property (irqReq |-> ctrlReg[7] && serialIrqEnable)
    else $error("Interrupt without both enables");
  a_idle_after_eot: assert property ($rose(irqReq) && sckOe && !modeSh |=> sckOut == ctrlReg[3])
    else $error("Shift clock not idle after byte");
  a_half_div4: assert property (sckOe && !ctrlReg[3] && ctrlReg[1:0] == 2'b00 && $rose(sckOut)
    |-> sckOut[*2] ##1 !sckOut)
    else $error("Shift clock high time wrong at divide by 4");
  a_half_div8: assert property (sckOe && !ctrlReg[3] && ctrlReg[1:0] == 2'b01 && $rose(sckOut)
    |-> sckOut[*4] ##1 !sckOut)
    else $error("Shift clock high time wrong at divide by 8");
  a_flag_clear: assert property (armedReg && dataAcc |=> !irqReq)
    else $error("Flag not cleared by status then data access");
endmodule : spi_master_slave_port_properties

// ==== spi_far_slave.sv ====
`timescale 1ns/10ps

module spi_far_slave (
  input wire logic sck,
  input wire logic csN,
  input wire logic mosi,
  input wire logic [7:0] txByte,
  output logic miso,
  output logic [7:0] rxByte
);
  logic [7:0] shiftReg = 8'h00;
  logic [7:0] rxReg = 8'h00;
  logic [3:0] bitCnt = 4'h0;
  logic idleLevel = 1'b1;

  // Reply loaded on select; once released the line shows the inverse of its last bit
  always @(negedge csN)
  begin
    shiftReg = txByte;
    bitCnt = 4'h0;
  end
  always @(posedge csN) idleLevel = ~shiftReg[7];

  // Samples on the rising edge, which serves modes 0 and 3
  always @(posedge sck)
    if (!csN)
    begin
      rxReg = {rxReg[6:0], mosi};
      bitCnt = bitCnt + 4'h1;
    end

  // Shifts only after a sample, so the leading fall in mode 3 keeps the first bit
  always @(negedge sck)
    if (!csN && bitCnt != 4'h0)
      shiftReg = {shiftReg[6:0], shiftReg[7]};

  assign miso = csN ? idleLevel : shiftReg[7];
  assign rxByte = rxReg;
endmodule : spi_far_slave

// ==== spi_master_slave_port_test.sv ====
`timescale 1ns/10ps
`include "spi_port_consts.svh"

module spi_master_slave_port_test;
  import spi_port_pkg::*;
  typedef struct packed {logic [7:0] ctrl; logic [7:0] tx; logic [7:0] slv; logic [7:0] half;} row_type;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] regAddr = 8'h00;
  reg_byte_type regWrData = 8'h00;
  logic regWrStrobe = 1'b0;
  logic regRdStrobe = 1'b0;
  logic serialIrqEnable = 1'b1;
  logic slaveSelectN = 1'b0;
  logic farCsN = 1'b1;
  reg_byte_type farTx = 8'h00;
  reg_byte_type regRdData, farRx, rdVal;
  logic irqReq, sckOut, sckOe, mosiOut, mosiOe, misoOut, misoOe, farMiso, sckLine, mosiLine, misoLine;
  int errorCnt = 0;
  int checks = 0;
  // Control value, byte sent, byte returned, half period in clocks
  row_type rows [4] = '{'{8'hD0, 8'hA5, 8'h3C, 8'h02}, '{8'hD1, 8'h81, 8'h7E, 8'h04},
    '{8'hDE, 8'h4B, 8'hE1, 8'h10}, '{8'hF3, 8'h1D, 8'hB8, 8'h20}};

  // Pin levels; a released mosi line shows the inverse so stale values cannot pass, a released miso line shows the far slave, a released clock reads low
  assign sckLine = sckOe ? sckOut : 1'b0;
  assign mosiLine = mosiOe ? mosiOut : ~mosiOut;
  assign misoLine = misoOe ? misoOut : farMiso;

  spi_master_slave_port #(.BYTE_W(8)) uut (.sys_clk(sys_clk), .arst_n(arst_n), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe), .regRdData(regRdData),
    .serialIrqEnable(serialIrqEnable), .irqReq(irqReq), .sckIn(sckLine), .sckOut(sckOut), .sckOe(sckOe),
    .mosiIn(mosiLine), .mosiOut(mosiOut), .mosiOe(mosiOe), .misoIn(misoLine), .misoOut(misoOut),
    .misoOe(misoOe), .slaveSelectN(slaveSelectN));
  spi_far_slave far (.sck(sckLine), .csN(farCsN), .mosi(mosiLine), .txByte(farTx), .miso(farMiso),
    .rxByte(farRx));

  always #20 sys_clk = ~sys_clk;

  function automatic logic [7:0] rev(input logic [7:0] b);
    for (int i = 0; i < 8; i++) rev[i] = b[7 - i];
  endfunction : rev

  task automatic chkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp)
    begin
      errorCnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chkByte

  task automatic chkCount(input string what, input int exp, input int got);
    checks++;
    if (got != exp)
    begin
      errorCnt++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chkCount

  // Bus cycles: strobe for one clock, then one quiet clock so no strobe is set twice at an edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWrStrobe <= 1'b1;
    @(posedge sys_clk);
    regWrStrobe <= 1'b0;
    @(posedge sys_clk);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    regAddr <= a;
    regRdStrobe <= 1'b1;
    @(posedge sys_clk);
    regRdStrobe <= 1'b0;
    @(posedge sys_clk);
    d = regRdData;
  endtask : rd

  task automatic rdChk(input logic [7:0] a, input logic [7:0] mask, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chkByte(what, exp, d & mask);
  endtask : rdChk

  task automatic waitIrq;
    for (int n = 0; n < 3000 && irqReq !== 1'b1; n++) @(posedge sys_clk);
  endtask : waitIrq

  // One master byte; counts clocks with the shift clock away from its idle level
  task automatic xfer(input row_type r);
    int act;
    act = 0;
    farTx <= r.slv;
    farCsN <= 1'b0;
    wr(`SPI_DATA_OFF, r.tx);
    for (int n = 0; n < 3000 && irqReq !== 1'b1; n++)
    begin
      @(posedge sys_clk);
      if (sckOut !== r.ctrl[3]) act++;
    end
    chkCount("active clocks", 8 * r.half, act);
    rdChk(`SPI_STATUS_OFF, 8'hE0, 8'h80, "status");
    rdChk(`SPI_DATA_OFF, 8'hFF, r.ctrl[5] ? rev(r.slv) : r.slv, "rx byte");
    chkByte("far rx", r.ctrl[5] ? rev(r.tx) : r.tx, farRx);
    chkByte("irq", 8'h00, {7'h00, irqReq});
    farCsN <= 1'b1;
    @(posedge sys_clk);
  endtask : xfer

  task automatic final_report;
    $display("Checks %0d errors %0d", checks, errorCnt);
    if (errorCnt == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : final_report

  // Main sequence: reset values, the row loop, then collision, masking and buffered cases
  initial
  begin
    repeat (2) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    rdChk(`SPI_CTRL_OFF, 8'hFF, `SPI_CTRL_RESET, "ctrl reset");
    rdChk(`SPI_STATUS_OFF, 8'hE3, 8'h00, "status reset");
    rdChk(`SPI_DATA_OFF, 8'hFF, `SPI_DATA_RESET, "data reset");
    wr(8'h10, 8'hFF);
    rdChk(8'h10, 8'hFF, 8'h00, "unmapped");
    rdChk(`SPI_CTRL_OFF, 8'hFF, 8'h00, "ctrl after unmapped write");
    for (int i = 0; i < 4; i++)
    begin
      wr(`SPI_CTRL_OFF, rows[i].ctrl & 8'hBF);
      wr(`SPI_CTRL_OFF, rows[i].ctrl);
      xfer(rows[i]);
    end
    // Write while shifting in normal mode is dropped
    wr(`SPI_CTRL_OFF, 8'hD1);
    farTx <= 8'h96;
    farCsN <= 1'b0;
    wr(`SPI_DATA_OFF, 8'h55);
    for (int n = 0; n < 100 && sckOut !== 1'b1; n++) @(posedge sys_clk);
    wr(`SPI_DATA_OFF, 8'hAA);
    waitIrq();
    rdChk(`SPI_STATUS_OFF, 8'hE0, 8'hC0, "collision status");
    rdChk(`SPI_DATA_OFF, 8'hFF, 8'h96, "collision rx");
    chkByte("collision far rx", 8'h55, farRx);
    rdChk(`SPI_STATUS_OFF, 8'hC0, 8'h00, "flags cleared");
    // Interrupt masked by either enable while the flag stands
    wr(`SPI_CTRL_OFF, 8'h51);
    wr(`SPI_DATA_OFF, 8'h3C);
    rdVal = 8'h00;
    for (int n = 0; n < 100 && rdVal[7] !== 1'b1; n++) rd(`SPI_STATUS_OFF, rdVal);
    chkByte("irq port masked", 8'h00, {7'h00, irqReq});
    wr(`SPI_CTRL_OFF, 8'hD1);
    chkByte("irq enabled", 8'h01, {7'h00, irqReq});
    serialIrqEnable <= 1'b0;
    @(posedge sys_clk);
    chkByte("irq serial masked", 8'h00, {7'h00, irqReq});
    serialIrqEnable <= 1'b1;
    rd(`SPI_STATUS_OFF, rdVal);
    rd(`SPI_DATA_OFF, rdVal);
    farCsN <= 1'b1;
    @(posedge sys_clk);
    // Buffered mode: start at once, hold the next byte, chain without a gap
    wr(`SPI_STATUS_OFF, 8'h01);
    farTx <= 8'hC3;
    farCsN <= 1'b0;
    wr(`SPI_DATA_OFF, 8'h11);
    rdChk(`SPI_STATUS_OFF, 8'h41, 8'h01, "idle start empties");
    wr(`SPI_DATA_OFF, 8'h22);
    rdChk(`SPI_STATUS_OFF, 8'h41, 8'h41, "buffer full");
    waitIrq();
    rdChk(`SPI_STATUS_OFF, 8'hE1, 8'hA1, "chained start");
    rdChk(`SPI_DATA_OFF, 8'hFF, 8'hC3, "first rx");
    waitIrq();
    chkByte("chained far rx", 8'h22, farRx);
    rd(`SPI_STATUS_OFF, rdVal);
    rd(`SPI_DATA_OFF, rdVal);
    farCsN <= 1'b1;
    final_report();
  end

  // The run needs under two thousand clocks; twenty thousand means a hang
  initial
  begin
    #(40 * 20000);
    errorCnt++;
    final_report();
  end
endmodule : spi_master_slave_port_test

bind spi_master_slave_port spi_master_slave_port_properties #(.BYTE_W(BYTE_W)) props (.sys_clk(sys_clk),
  .arst_n(arst_n), .regAddr(regAddr), .regWrData(regWrData), .regWrStrobe(regWrStrobe),
  .regRdStrobe(regRdStrobe), .regRdData(regRdData), .serialIrqEnable(serialIrqEnable), .irqReq(irqReq),
  .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .mosiIn(mosiIn), .mosiOut(mosiOut), .mosiOe(mosiOe),
  .misoIn(misoIn), .misoOut(misoOut), .misoOe(misoOe), .slaveSelectN(slaveSelectN));
